// ---- logic/flag_op_decoder.sv ----
/*
 * flag and control op decoder: executes single-word flag set/clear ops
 * and control ops, holds the status flags and raises control strobes.
 * assumes the fetch stage presents at most one opcode per cycle on MCLK
 * and that sleep, watchdog and debug units sample one-cycle strobes.
 */
//
// Contract
// RULE_01: overflow set/clear ops, one cycle, V only
// RULE_02: half-carry set/clear ops, one cycle, H only
// RULE_03: transfer set/clear ops, one cycle, T only
// RULE_04: idle op changes nothing, always executes
// RULE_05: sleep op: one cycle, strobe sleep logic
// RULE_06: watchdog op: one cycle, restart strobe, flags kept
// RULE_07: break op only for debug, flags kept
//
`include "flag_op_map.svh"

module flag_op_decoder (
    input wire logic MCLK,
    input wire logic RST_B,
    input wire flag_op_pkg::op_req_t OP_IN,
    input wire logic DEBUG_EN,
    input wire flag_op_pkg::flag_load_t FLAG_LOAD,
    output logic [`FLAGS_W-1:0] FLAGS_OUT,
    output flag_op_pkg::ctrl_strobe_t CTRL_OUT,
    output logic OP_DONE,
    output logic OP_UNKNOWN
);

    // ------------------------------------------------------------------
    // constants
    // ------------------------------------------------------------------
    localparam logic [`FLAGS_W-1:0] V_MASK = `FLAGS_W'(1) << `FLAG_BIT_V;
    localparam logic [`FLAGS_W-1:0] H_MASK = `FLAGS_W'(1) << `FLAG_BIT_H;
    localparam logic [`FLAGS_W-1:0] T_MASK = `FLAGS_W'(1) << `FLAG_BIT_T;
    localparam int OP_CYC = `OP_CYCLES;   // every op here retires in this

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    flag_op_pkg::dec_state_t st_q;        // all registered state
    flag_op_pkg::dec_state_t st_d;        // its next value
    flag_op_pkg::op_kind_t kind;          // decoded kind of OP_IN.code

    // ------------------------------------------------------------------
    // opcode classification
    // ------------------------------------------------------------------
    op_classify u_classify (
        .code(OP_IN.code),
        .kind(kind)
    );

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    // the core's whole-byte load is applied first, then the op touches its
    // own bit, so an op and a load in one cycle still leave the op's flag
    // as the op demands and every other bit as the load gave it
    always_comb begin
        st_d = st_q;
        st_d.ctrl = '0;                   // strobes last one cycle
        st_d.done = 1'b0;
        st_d.unknown = 1'b0;
        if (FLAG_LOAD.en) begin
            st_d.flags = FLAG_LOAD.data;
        end
        if (OP_IN.valid) begin
            st_d.done = 1'b1;             // every op of this group retires in one cycle
            case (kind)
                flag_op_pkg::K_V_SET: begin
                    st_d.flags = st_d.flags | V_MASK;            // [RULE_01]
                end
                flag_op_pkg::K_V_CLR: begin
                    st_d.flags = st_d.flags & ~V_MASK;           // [RULE_01]
                end
                flag_op_pkg::K_H_SET: begin
                    st_d.flags = st_d.flags | H_MASK;            // [RULE_02]
                end
                flag_op_pkg::K_H_CLR: begin
                    st_d.flags = st_d.flags & ~H_MASK;           // [RULE_02]
                end
                flag_op_pkg::K_T_SET: begin
                    st_d.flags = st_d.flags | T_MASK;            // [RULE_03]
                end
                flag_op_pkg::K_T_CLR: begin
                    st_d.flags = st_d.flags & ~T_MASK;           // [RULE_03]
                end
                flag_op_pkg::K_IDLE: begin
                    // no state touched; needs no settled timing path,
                    // so it is safe right after a clock change [RULE_04]
                end
                flag_op_pkg::K_SLEEP: begin
                    st_d.ctrl.sleep = 1'b1;                      // [RULE_05]
                end
                flag_op_pkg::K_WDOG: begin
                    st_d.ctrl.wdog = 1'b1;                       // [RULE_06]
                end
                flag_op_pkg::K_BREAK: begin
                    // without debug support the op behaves as idle
                    st_d.ctrl.brk = DEBUG_EN;                    // [RULE_07]
                end
                default: begin
                    // not in this group: another unit executes it
                    st_d.done = 1'b0;
                    st_d.unknown = 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            st_q <= '{flags: `FLAGS_RESET, ctrl: '0, done: 1'b0, unknown: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs, straight from the state register
    // ------------------------------------------------------------------
    assign FLAGS_OUT = st_q.flags;
    assign CTRL_OUT = st_q.ctrl;
    assign OP_DONE = st_q.done;
    assign OP_UNKNOWN = st_q.unknown;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_B);

    // helper: an op of the given kind was taken without a concurrent load
    logic plain_op;
    assign plain_op = OP_IN.valid && !FLAG_LOAD.en;

    a_overflow_set: assert property ( // [RULE_01]
        plain_op && kind == flag_op_pkg::K_V_SET |=>
            FLAGS_OUT[`FLAG_BIT_V] && ((FLAGS_OUT & ~V_MASK) == $past(FLAGS_OUT & ~V_MASK))
    ) else $error("overflow set op wrong");

    a_overflow_clear: assert property ( // [RULE_01]
        plain_op && kind == flag_op_pkg::K_V_CLR |=>
            !FLAGS_OUT[`FLAG_BIT_V] && ((FLAGS_OUT & ~V_MASK) == $past(FLAGS_OUT & ~V_MASK))
    ) else $error("overflow clear op wrong");

    a_half_carry_op: assert property ( // [RULE_02]
        plain_op && (kind == flag_op_pkg::K_H_SET || kind == flag_op_pkg::K_H_CLR) |=>
            FLAGS_OUT[`FLAG_BIT_H] == ($past(kind) == flag_op_pkg::K_H_SET)
            && ((FLAGS_OUT & ~H_MASK) == $past(FLAGS_OUT & ~H_MASK))
    ) else $error("half carry op wrong");

    a_transfer_op: assert property ( // [RULE_03]
        plain_op && (kind == flag_op_pkg::K_T_SET || kind == flag_op_pkg::K_T_CLR) |=>
            FLAGS_OUT[`FLAG_BIT_T] == ($past(kind) == flag_op_pkg::K_T_SET)
            && ((FLAGS_OUT & ~T_MASK) == $past(FLAGS_OUT & ~T_MASK))
    ) else $error("transfer op wrong");

    a_idle_keeps: assert property ( // [RULE_04]
        plain_op && kind == flag_op_pkg::K_IDLE |=>
            $stable(FLAGS_OUT) && CTRL_OUT == '0 && OP_DONE
    ) else $error("idle op changed state");

    // a sleep op right behind another legally keeps the strobe up a second
    // cycle, so the drop is only demanded when the previous op was not sleep
    a_sleep_strobe: assert property ( // [RULE_05]
        plain_op && kind == flag_op_pkg::K_SLEEP |=>
            CTRL_OUT.sleep && $stable(FLAGS_OUT) && OP_DONE
            ##1 (!CTRL_OUT.sleep || $past(OP_IN.valid && kind == flag_op_pkg::K_SLEEP))
    ) else $error("sleep strobe wrong");

    a_wdog_strobe: assert property ( // [RULE_06]
        plain_op && kind == flag_op_pkg::K_WDOG |=>
            CTRL_OUT.wdog && $stable(FLAGS_OUT) && !CTRL_OUT.sleep
    ) else $error("watchdog restart wrong");

    a_break_gated: assert property ( // [RULE_07]
        CTRL_OUT.brk |-> $past(OP_IN.valid && kind == flag_op_pkg::K_BREAK && DEBUG_EN)
    ) else $error("break strobe without debug");

    a_break_flags: assert property ( // [RULE_07]
        plain_op && kind == flag_op_pkg::K_BREAK |=> $stable(FLAGS_OUT)
    ) else $error("break op changed flags");

    a_retire_time: assert property ( // [RULE_01]
        OP_IN.valid && kind != flag_op_pkg::K_NONE |-> ##OP_CYC OP_DONE
    ) else $error("op did not retire in one cycle");

    // strobes only ever follow their own op: a stray pulse would restart the
    // watchdog or put the core to sleep with no instruction behind it
    a_sleep_source: assert property ( // [RULE_05]
        CTRL_OUT.sleep |-> $past(OP_IN.valid && kind == flag_op_pkg::K_SLEEP)
    ) else $error("sleep strobe without sleep op");

    a_wdog_source: assert property ( // [RULE_06]
        CTRL_OUT.wdog |-> $past(OP_IN.valid && kind == flag_op_pkg::K_WDOG)
    ) else $error("restart strobe without watchdog op");

    a_break_strobe: assert property ( // [RULE_07]
        OP_IN.valid && kind == flag_op_pkg::K_BREAK && DEBUG_EN |=> CTRL_OUT.brk && OP_DONE
    ) else $error("break op with debug gave no strobe");

    // a code of another unit must leave this group's state alone
    a_foreign_op: assert property ( // [RULE_04]
        plain_op && kind == flag_op_pkg::K_NONE |=>
            OP_UNKNOWN && !OP_DONE && CTRL_OUT == '0 && $stable(FLAGS_OUT)
    ) else $error("foreign op touched this group");

    c_overflow_pair: cover property (
        OP_IN.valid && kind == flag_op_pkg::K_V_SET ##1 OP_IN.valid && kind == flag_op_pkg::K_V_CLR
    );
    c_idle_run: cover property (
        (OP_IN.valid && kind == flag_op_pkg::K_IDLE) [*8]
    );
    c_sleep_seen: cover property (CTRL_OUT.sleep);
    c_break_seen: cover property (CTRL_OUT.brk);
    c_foreign_seen: cover property (OP_UNKNOWN);

endmodule

// ---- logic/flag_op_map.svh ----
/*
 * constants of the flag and control op decoder: opcode values, flag bit
 * positions, reset values and cycle counts.
 * assumes it is included by bare name wherever a constant is needed.
 */
`ifndef FLAG_OP_MAP_SVH
`define FLAG_OP_MAP_SVH

// ----------------------------------------------------------------------
// opcode field
// ----------------------------------------------------------------------
`define OPC_W 8
`define OPC_IDLE 8'h00
`define OPC_V_SET 8'h01
`define OPC_V_CLR 8'h02
`define OPC_T_SET 8'h03
`define OPC_T_CLR 8'h04
`define OPC_H_SET 8'h05
`define OPC_H_CLR 8'h06
`define OPC_SLEEP 8'h07
`define OPC_WDOG 8'h08
`define OPC_BREAK 8'h09

// ----------------------------------------------------------------------
// status flag layout and reset value
// ----------------------------------------------------------------------
`define FLAGS_W 8
`define FLAG_BIT_V 3
`define FLAG_BIT_H 5
`define FLAG_BIT_T 6
`define FLAGS_RESET 8'h00

// ----------------------------------------------------------------------
// timing: cycles each op occupies
// ----------------------------------------------------------------------
`define OP_CYCLES 1

`endif

// ---- logic/flag_op_pkg.sv ----
/*
 * types shared by the flag and control op decoder and its classifier.
 * assumes flag_op_map.svh is on the include path.
 */
`include "flag_op_map.svh"

package flag_op_pkg;

    // ------------------------------------------------------------------
    // decoded operation kinds
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        K_NONE,
        K_IDLE,
        K_V_SET,
        K_V_CLR,
        K_T_SET,
        K_T_CLR,
        K_H_SET,
        K_H_CLR,
        K_SLEEP,
        K_WDOG,
        K_BREAK
    } op_kind_t;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic valid;                      // opcode presented this cycle
        logic [`OPC_W-1:0] code;          // opcode value
    } op_req_t;

    typedef struct packed {
        logic en;                         // core loads the whole flag byte
        logic [`FLAGS_W-1:0] data;        // value to load
    } flag_load_t;

    typedef struct packed {
        logic sleep;                      // hand-off to sleep logic
        logic wdog;                       // watchdog restart
        logic brk;                        // debug break request
    } ctrl_strobe_t;

    typedef struct packed {
        logic [`FLAGS_W-1:0] flags;       // status flags register
        ctrl_strobe_t ctrl;               // control strobes
        logic done;                       // op retired
        logic unknown;                    // opcode not in this group
    } dec_state_t;

endpackage

// ---- logic/op_classify.sv ----
/*
 * combinational opcode classifier for the flag and control op group.
 * assumes the opcode comes from a register in the fetch stage.
 */
`include "flag_op_map.svh"

module op_classify (
    input wire logic [`OPC_W-1:0] code,
    output flag_op_pkg::op_kind_t kind
);

    // ------------------------------------------------------------------
    // opcode lookup
    // ------------------------------------------------------------------
    // plain compare table; anything outside the group reports K_NONE
    always_comb begin
        case (code)
            `OPC_IDLE: kind = flag_op_pkg::K_IDLE;
            `OPC_V_SET: kind = flag_op_pkg::K_V_SET;
            `OPC_V_CLR: kind = flag_op_pkg::K_V_CLR;
            `OPC_T_SET: kind = flag_op_pkg::K_T_SET;
            `OPC_T_CLR: kind = flag_op_pkg::K_T_CLR;
            `OPC_H_SET: kind = flag_op_pkg::K_H_SET;
            `OPC_H_CLR: kind = flag_op_pkg::K_H_CLR;
            `OPC_SLEEP: kind = flag_op_pkg::K_SLEEP;
            `OPC_WDOG: kind = flag_op_pkg::K_WDOG;
            `OPC_BREAK: kind = flag_op_pkg::K_BREAK;
            default: kind = flag_op_pkg::K_NONE;
        endcase
    end

endmodule

// ---- tb/fetch_model.sv ----
/*
 * fetch stage stand-in: presents one opcode per MCLK cycle to the decoder.
 * assumes the caller enters drive just after a rising edge of clk.
 */
`include "flag_op_map.svh"

module fetch_model (
    input wire logic clk,
    output flag_op_pkg::op_req_t req
);
    timeunit 1ns;
    timeprecision 100ps;

    // last code put out, kept so a released bus never repeats it
    logic [`OPC_W-1:0] last_code;

    initial begin
        last_code = 8'h00;
        req = '0;
    end

    // ------------------------------------------------------------------
    // one cycle of fetch: request held across exactly one rising edge
    // ------------------------------------------------------------------
    // released code is inverted so a stale opcode cannot look valid
    task automatic drive(input logic v, input logic [`OPC_W-1:0] code);
        if (v) begin
            req = {1'b1, code};
            last_code = code;
        end else begin
            req = {1'b0, ~last_code};
        end
        @(posedge clk);
        #1;
    endtask
endmodule

// ---- tb/tb_top.sv ----
/*
 * self-checking bench of the flag and control op decoder.
 * assumes the decoder answers just after the same edge that takes a request.
 */
`include "flag_op_map.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------------
    // signals and expected status codes {done, unknown, sleep, wdog, brk}
    // ------------------------------------------------------------------
    logic MCLK;
    logic RST_B;
    logic DEBUG_EN;
    flag_op_pkg::op_req_t op_req;
    flag_op_pkg::flag_load_t ld;
    logic [`FLAGS_W-1:0] flags;
    flag_op_pkg::ctrl_strobe_t ctrl;
    logic done;
    logic unk;
    int n_mismatch = 0;
    int num_checks = 0;
    logic [7:0] exp_f;
    localparam logic [4:0] ST_DONE = 5'h10;
    localparam logic [4:0] ST_SLP = 5'h14;
    localparam logic [4:0] ST_WDOG = 5'h12;
    localparam logic [4:0] ST_BRK = 5'h11;
    localparam logic [4:0] ST_UNK = 5'h08;

    fetch_model fm (.clk(MCLK), .req(op_req));

    flag_op_decoder uut (
        .MCLK(MCLK), .RST_B(RST_B), .OP_IN(op_req), .DEBUG_EN(DEBUG_EN),
        .FLAG_LOAD(ld), .FLAGS_OUT(flags), .CTRL_OUT(ctrl), .OP_DONE(done),
        .OP_UNKNOWN(unk)
    );

    initial begin
        MCLK = 1'b0;
        forever #4 MCLK = ~MCLK;
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // load and op go out in the same step, so nothing is assigned twice
    task automatic step(input logic le, input logic [7:0] d, input logic v, input logic [7:0] c);
        ld = {le, d};
        fm.drive(v, c);
    endtask

    task automatic expect_out(input logic [7:0] f, input logic [4:0] st);
        chk("flags", f, flags);
        chk("status", {3'b000, st}, {3'b000, done, unk, ctrl});
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    // reset also lands in mid-run, after flags were loaded non-zero
    task automatic do_reset;
        RST_B = 1'b0;
        repeat (4) step(1'b0, 8'h00, 1'b0, 8'h00);
        RST_B = 1'b1;
        step(1'b0, 8'h00, 1'b0, 8'h00);
        expect_out(`FLAGS_RESET, 5'b00000);
    endtask

    // six flag ops back to back, from all-clear and all-set bytes
    task automatic test_flag_ops;
        logic [7:0] code [6] = '{`OPC_V_SET, `OPC_V_CLR, `OPC_T_SET,
                                 `OPC_T_CLR, `OPC_H_SET, `OPC_H_CLR};
        int pos [6] = '{`FLAG_BIT_V, `FLAG_BIT_V, `FLAG_BIT_T,
                        `FLAG_BIT_T, `FLAG_BIT_H, `FLAG_BIT_H};
        logic [7:0] pre [2] = '{8'h00, 8'hFF};
        for (int p = 0; p < 2; p++) begin
            exp_f = pre[p];
            step(1'b1, exp_f, 1'b0, 8'h00);
            for (int i = 0; i < 6; i++) begin
                step(1'b0, 8'h00, 1'b1, code[i]);
                exp_f[pos[i]] = ~i[0];
                expect_out(exp_f, ST_DONE);
            end
        end
    endtask

    // control ops keep flags and pulse their strobe for one cycle only
    task automatic test_control;
        step(1'b1, 8'h5A, 1'b0, 8'h00);
        repeat (8) begin
            step(1'b0, 8'h00, 1'b1, `OPC_IDLE);
            expect_out(8'h5A, ST_DONE);
        end
        DEBUG_EN = 1'b1;
        step(1'b0, 8'h00, 1'b1, `OPC_SLEEP);
        expect_out(8'h5A, ST_SLP);
        step(1'b0, 8'h00, 1'b1, `OPC_SLEEP);
        expect_out(8'h5A, ST_SLP);
        step(1'b0, 8'h00, 1'b1, `OPC_WDOG);
        expect_out(8'h5A, ST_WDOG);
        step(1'b0, 8'h00, 1'b1, `OPC_BREAK);
        expect_out(8'h5A, ST_BRK);
        DEBUG_EN = 1'b0;
        step(1'b0, 8'h00, 1'b1, `OPC_BREAK);
        expect_out(8'h5A, ST_DONE);
        step(1'b0, 8'h00, 1'b1, 8'hA7);
        expect_out(8'h5A, ST_UNK);
        step(1'b0, 8'h00, 1'b0, 8'h00);
        expect_out(8'h5A, 5'b00000);
    endtask

    // load in the same cycle as an op: only the op's own bit overrides
    task automatic test_collision;
        step(1'b1, 8'h00, 1'b1, `OPC_H_SET);
        expect_out(8'h01 << `FLAG_BIT_H, ST_DONE);
        step(1'b1, 8'hFF, 1'b1, `OPC_T_CLR);
        expect_out(~(8'h01 << `FLAG_BIT_T), ST_DONE);
        step(1'b1, 8'hC3, 1'b1, `OPC_WDOG);
        expect_out(8'hC3, ST_WDOG);
        step(1'b1, 8'h3C, 1'b1, 8'hA7);
        expect_out(8'h3C, ST_UNK);
    endtask

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        RST_B = 1'b0;
        DEBUG_EN = 1'b0;
        ld = '0;
        do_reset();
        test_flag_ops();
        test_control();
        test_collision();
        do_reset();
        complete_run();
    end

    // the run needs under 80 cycles; this span leaves a wide margin
    initial begin
        #20000;
        n_mismatch++;
        complete_run();
    end
endmodule
